/* File: rtl/rail_setpoint_slew_control.sv */
// Ramp control and aux regulator voltage registers with core buck ramp engines
// How it works
// RL1: Trigger write ramps both core bucks to set-points
// RL2: Trigger self-clears at ramp end; zero write ignored
// RL3: Bypass set: each set-point update ramps at once
// RL4: Rate code 0h-6h: 160 us halving to 2.5 us
// RL5: Rate code 7h applies set-point with no dwell
// RL6: Dwell counted per code step, not per volt
// RL7: Aux regulator register at 0x1B, resets 0x33
// RL8: Aux register accepts only password-protected writes
// RL9: Every accepted (password-protected) aux write blanks rail monitoring 5 ms
// RL10: Six-bit aux code, upper bits read zero
// RL11: Ramp control at 0x1A, resets 0x06, fixed layout
// RL12: Pacing applies only to the two core bucks
// RL13: Advance one code per interval until target reached
`timescale 1ns/10ps
module rail_setpoint_slew_control #(
    parameter int                            CODE_W      = rail_setpoint_pkg::CORE_CODE_W,
    parameter int                            STEP_W      = 16,
    parameter int                            STEP_MIN    = rail_setpoint_pkg::STEP_MIN_CYCLES,
    parameter int                            BLANK_LEN   = rail_setpoint_pkg::BLANK_CYCLES,
    parameter logic [CODE_W-1:0]             RESET_LEVEL = '0
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Register access port, fed by the serial front end
    input  wire logic              regWrEn,          // One-cycle write strobe
    input  wire logic              regRdEn,          // One-cycle read strobe
    input  wire logic [7:0]        regAddr,          // Register subaddress
    input  wire logic [7:0]        regWrData,        // Write data
    input  wire logic              regWrProtected,   // Write came via password procedure
    output logic      [7:0]        regRdData,        // Read data, one cycle after strobe
    // Core buck one set-point
    input  wire logic [CODE_W-1:0] coreBuckOneSetpoint,
    input  wire logic              coreBuckOneUpdate,
    // Core buck two set-point
    input  wire logic [CODE_W-1:0] coreBuckTwoSetpoint,
    input  wire logic              coreBuckTwoUpdate,
    // Applied core buck codes
    output logic      [CODE_W-1:0] coreBuckOneLevel,
    output logic      [CODE_W-1:0] coreBuckTwoLevel,
    output logic                   rampBusy,
    // Aux linear regulator
    output logic      [rail_setpoint_pkg::AUX_CODE_W-1:0] auxLinearRegulatorCode,
    output logic                   auxLinearRegulatorBlank
);

    localparam int NCH = 2;  // Paced core buck rails

    // Parameter sanity: the slowest dwell must fit the counter
    if (CODE_W < 1 || CODE_W > 8) begin : g_chk_code
        $error("CODE_W must lie in 1..8");
    end
    if (STEP_MIN < 1) begin : g_chk_step
        $error("STEP_MIN must be at least one cycle");
    end
    if (longint'(STEP_MIN) * 64 >= (longint'(1) << STEP_W)) begin : g_chk_width
        $error("STEP_W too narrow for the slowest dwell");
    end

    typedef struct packed {
        logic                                   trig;     // Transition trigger
        logic                                   bypass;   // Trigger bypass
        logic [rail_setpoint_pkg::RATE_W-1:0]   rate;     // Dwell rate code
        logic [rail_setpoint_pkg::AUX_CODE_W-1:0] auxCode; // Aux regulator code
        logic [7:0]                             rdData;   // Registered read data
    } regs_s;

    regs_s st_r;   // Registered state
    regs_s st_nxt; // Next state

    // Decoded accesses
    logic ctrlWrite;  // Write to ramp control
    logic auxWrite;   // Accepted write to aux register
    logic trigWrite;  // Write of one to the trigger
    logic [7:0] ctrlView;  // Ramp control as read back
    logic [7:0] auxView;   // Aux register as read back

    // Channel wiring, indexed by rail
    logic [CODE_W-1:0] chTarget [NCH];  // Present set-point per rail
    logic              chUpdate [NCH];  // Set-point update strobe per rail
    logic              chStart  [NCH];  // Ramp start per rail
    logic [CODE_W-1:0] chLevel  [NCH];  // Applied code per rail
    logic              chBusy   [NCH];  // Ramp under way per rail
    logic              anyBusy;         // Either rail ramping
    logic [STEP_W-1:0] stepCycles;      // Dwell for the present rate
    logic              immediate;       // Rate code asks for no dwell
    logic [rail_setpoint_pkg::RATE_W-1:0] rateNow;  // Rate in force this cycle

    // Address decode for writes
    always_comb begin
        ctrlWrite = regWrEn && (regAddr == rail_setpoint_pkg::RAMP_CTRL_ADDR); // RL11
        // Unprotected writes to the aux register are dropped silently
        auxWrite  = regWrEn && regWrProtected && (regAddr == rail_setpoint_pkg::AUX_VOLT_ADDR); // RL8
        trigWrite = ctrlWrite && regWrData[rail_setpoint_pkg::TRIG_BIT]; // RL1
    end

    // Read-back images; reserved bits read zero
    always_comb begin
        ctrlView = 8'h00;
        ctrlView[rail_setpoint_pkg::TRIG_BIT]   = st_r.trig; // RL11
        ctrlView[rail_setpoint_pkg::BYPASS_BIT] = st_r.bypass;
        ctrlView[rail_setpoint_pkg::RATE_LSB +: rail_setpoint_pkg::RATE_W] = st_r.rate;
        auxView  = 8'h00;
        auxView[rail_setpoint_pkg::AUX_CODE_LSB +: rail_setpoint_pkg::AUX_CODE_W] = st_r.auxCode; // RL10
    end

    // Rail inputs gathered so the engines share one loop
    always_comb begin
        chTarget[0] = coreBuckOneSetpoint;
        chTarget[1] = coreBuckTwoSetpoint;
        chUpdate[0] = coreBuckOneUpdate;
        chUpdate[1] = coreBuckTwoUpdate;
    end

    // Dwell length: fastest dwell doubled once per code below 6h
    always_comb begin
        // A rate written together with the trigger must pace the ramp it starts
        rateNow    = ctrlWrite ? regWrData[rail_setpoint_pkg::RATE_LSB +: rail_setpoint_pkg::RATE_W] : st_r.rate;
        immediate  = (rateNow == rail_setpoint_pkg::RATE_IMMEDIATE); // RL5
        stepCycles = STEP_W'(STEP_MIN) << (rail_setpoint_pkg::RATE_FASTEST - rateNow); // RL4
        if (immediate) begin
            // Shift would wrap; the dwell is unused anyway
            stepCycles = STEP_W'(STEP_MIN);
        end
    end

    // One ramp engine per core buck; other rails never pass through here
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        // Trigger moves both rails; bypass lets an update move its own rail
        assign chStart[i] = trigWrite || (st_r.bypass && chUpdate[i]); // RL3

        ramp_channel #(
            .CODE_W      (CODE_W),
            .STEP_W      (STEP_W),
            .RESET_LEVEL (RESET_LEVEL)
        ) u_ramp (
            .clk        (clk),
            .rst_n      (rst_n),
            .start      (chStart[i]), // RL12
            .target     (chTarget[i]),
            .stepCycles (stepCycles),
            .immediate  (immediate),
            .level      (chLevel[i]),
            .busy       (chBusy[i])
        );
    end

    assign anyBusy = chBusy[0] || chBusy[1];

    // Register update and registered read path
    always_comb begin
        st_nxt = st_r;
        // Ramp control fields
        if (ctrlWrite) begin
            st_nxt.bypass = regWrData[rail_setpoint_pkg::BYPASS_BIT]; // RL3
            st_nxt.rate   = regWrData[rail_setpoint_pkg::RATE_LSB +: rail_setpoint_pkg::RATE_W]; // RL4
        end
        // Trigger: a fresh write of one beats the completion clear
        if (trigWrite) begin
            st_nxt.trig = 1'b1; // RL1
        end else if (st_r.trig && !anyBusy) begin
            // Engines already took the start, so idle means finished
            st_nxt.trig = 1'b0; // RL2
        end
        // Aux regulator code, applied without pacing
        if (auxWrite) begin
            st_nxt.auxCode = regWrData[rail_setpoint_pkg::AUX_CODE_LSB +: rail_setpoint_pkg::AUX_CODE_W]; // RL12
        end
        // Read data holds until the next read strobe
        if (regRdEn) begin
            case (regAddr)
                rail_setpoint_pkg::RAMP_CTRL_ADDR: st_nxt.rdData = ctrlView;
                rail_setpoint_pkg::AUX_VOLT_ADDR:  st_nxt.rdData = auxView; // RL7
                default:                           st_nxt.rdData = 8'h00;
            endcase
        end
    end

    // State register; reset loads the documented register images
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r.trig    <= rail_setpoint_pkg::RAMP_CTRL_RESET[rail_setpoint_pkg::TRIG_BIT]; // RL11
            st_r.bypass  <= rail_setpoint_pkg::RAMP_CTRL_RESET[rail_setpoint_pkg::BYPASS_BIT]; // RL3
            st_r.rate    <= rail_setpoint_pkg::RAMP_CTRL_RESET[rail_setpoint_pkg::RATE_LSB +:
                                                               rail_setpoint_pkg::RATE_W]; // RL4
            st_r.auxCode <= rail_setpoint_pkg::AUX_VOLT_RESET[rail_setpoint_pkg::AUX_CODE_LSB +:
                                                              rail_setpoint_pkg::AUX_CODE_W]; // RL7
            st_r.rdData  <= 8'h00;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Monitor blanking, restarted by each accepted aux write
    blank_timer #(
        .CYCLES (BLANK_LEN)
    ) u_blank (
        .clk   (clk),
        .rst_n (rst_n),
        .load  (auxWrite), // RL9
        .blank (auxLinearRegulatorBlank)
    );

    // Outputs
    assign regRdData              = st_r.rdData;
    assign coreBuckOneLevel       = chLevel[0];
    assign coreBuckTwoLevel       = chLevel[1];
    assign rampBusy               = anyBusy;
    assign auxLinearRegulatorCode = st_r.auxCode; // RL10

endmodule

/* File: include/rail_setpoint_pkg.sv */
// Shared constants for the rail set-point and ramp control block
package rail_setpoint_pkg;

    // Register subaddresses
    localparam logic [7:0] RAMP_CTRL_ADDR  = 8'h1A;  // Ramp control register
    localparam logic [7:0] AUX_VOLT_ADDR   = 8'h1B;  // Aux linear regulator voltage register

    // Reset values
    localparam logic [7:0] RAMP_CTRL_RESET = 8'h06;  // Trigger 0, bypass 0, rate 6h
    localparam logic [7:0] AUX_VOLT_RESET  = 8'h33;  // Code 33h, 2.800 V

    // Ramp control field layout
    localparam int         TRIG_BIT        = 7;      // Self-clearing transition trigger
    localparam int         BYPASS_BIT      = 6;      // Trigger bypass
    localparam int         RATE_LSB        = 0;      // Rate code low bit
    localparam int         RATE_W          = 3;      // Rate code width

    // Aux regulator field layout
    localparam int         AUX_CODE_LSB    = 0;      // Regulator code low bit
    localparam int         AUX_CODE_W      = 6;      // Regulator code width

    // Rate code meanings
    localparam logic [2:0] RATE_IMMEDIATE  = 3'h7;   // No per-step dwell
    localparam logic [2:0] RATE_FASTEST    = 3'h6;   // Shortest paced dwell

    // Default core buck code width
    localparam int         CORE_CODE_W     = 6;      // Set-point code width

    // Timing
    localparam int         CLK_FREQ_MHZ    = 200;    // System clock rate
    localparam int         STEP_MIN_NS     = 2500;   // 2.5 us dwell at rate 6h
    localparam int         STEP_MIN_CYCLES = (STEP_MIN_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int         BLANK_TIME_MS   = 5;      // Monitor blanking after aux write
    localparam int         BLANK_CYCLES    = BLANK_TIME_MS * CLK_FREQ_MHZ * 1000;

endpackage

/* File: rtl/ramp_channel.sv */
// One core buck set-point ramp engine
`timescale 1ns/10ps
module ramp_channel #(
    parameter int                CODE_W      = 6,   // Set-point code width
    parameter int                STEP_W      = 16,  // Dwell counter width
    parameter logic [CODE_W-1:0] RESET_LEVEL = '0   // Applied code after reset
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Ramp request
    input  wire logic              start,       // Latch target, begin ramp
    input  wire logic [CODE_W-1:0] target,      // Requested set-point code
    input  wire logic [STEP_W-1:0] stepCycles,  // Dwell per code step
    input  wire logic              immediate,   // Apply target with no dwell
    // Result
    output logic      [CODE_W-1:0] level,       // Applied set-point code
    output logic                   busy         // Ramp under way
);

    typedef enum logic {IDLE, RAMP} ramp_e;

    typedef struct packed {
        ramp_e             state;   // Engine state
        logic [CODE_W-1:0] goal;    // Latched target
        logic [CODE_W-1:0] level;   // Present applied code
        logic [STEP_W-1:0] cnt;     // Remaining dwell cycles
    } chan_s;

    chan_s st_r;   // Registered state
    chan_s st_nxt; // Next state

    // Step toward the goal once the dwell expires
    always_comb begin
        st_nxt = st_r;
        case (st_r.state)
            IDLE: begin
                // Nothing to do until a request
            end
            RAMP: begin
                if (immediate) begin
                    st_nxt.level = st_r.goal; // RL5
                    st_nxt.state = IDLE;
                end else if (st_r.cnt != '0) begin
                    st_nxt.cnt = st_r.cnt - 1'b1;
                end else begin
                    // One code per expired interval
                    if (st_r.level < st_r.goal) begin
                        st_nxt.level = st_r.level + 1'b1; // RL13
                    end else if (st_r.level > st_r.goal) begin
                        st_nxt.level = st_r.level - 1'b1; // RL13
                    end
                    st_nxt.cnt = stepCycles - 1'b1; // RL6
                    if (st_nxt.level == st_r.goal) begin
                        st_nxt.state = IDLE; // RL13
                    end
                end
            end
            default: begin
                st_nxt.state = IDLE;
            end
        endcase
        // A new request retargets and restarts the dwell
        if (start) begin
            st_nxt.goal = target; // RL1
            st_nxt.cnt  = stepCycles - 1'b1; // RL4
            if (immediate) begin
                st_nxt.level = target; // RL5
                st_nxt.state = IDLE;
            end else if (target == st_nxt.level) begin
                st_nxt.state = IDLE;
            end else begin
                st_nxt.state = RAMP;
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{state: IDLE, goal: RESET_LEVEL, level: RESET_LEVEL, cnt: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.level;
    assign busy  = (st_r.state == RAMP);

endmodule

/* File: rtl/blank_timer.sv */
// Retriggerable monitor blanking timer
`timescale 1ns/10ps
module blank_timer #(
    parameter int CYCLES = 1000000  // Blanking length in clock cycles
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Control
    input  wire logic load,   // Restart the blanking window
    // Result
    output logic      blank   // Monitoring blanked
);

    localparam int W = $clog2(CYCLES + 1);  // Counter width

    if (CYCLES < 1) begin : g_chk
        $error("blank_timer needs CYCLES of one or more");
    end

    typedef struct packed {
        logic [W-1:0] cnt;    // Cycles left
        logic         blank;  // Registered blank flag
    } blank_s;

    blank_s st_r;   // Registered state
    blank_s st_nxt; // Next state

    // Reload on every write, else count down to zero
    always_comb begin
        st_nxt = st_r;
        if (load) begin
            st_nxt.cnt = W'(CYCLES);
        end else if (st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
        end
        st_nxt.blank = (st_nxt.cnt != '0);
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign blank = st_r.blank;

endmodule

/* File: verif/rail_setpoint_monitor.sv */
// Assertion checker for the rail set-point ramp block
`timescale 1ns/10ps
module rail_setpoint_monitor #(
    parameter int CODE_W    = 6,
    parameter int BLANK_LEN = 20
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst_n,
    // Register port
    input wire logic              regWrEn,
    input wire logic              regRdEn,
    input wire logic [7:0]        regAddr,
    input wire logic [7:0]        regWrData,
    input wire logic              regWrProtected,
    input wire logic [7:0]        regRdData,
    // Rails
    input wire logic              coreBuckOneUpdate,
    input wire logic [CODE_W-1:0] coreBuckOneLevel,
    input wire logic              rampBusy,
    input wire logic [rail_setpoint_pkg::AUX_CODE_W-1:0] auxLinearRegulatorCode,
    input wire logic              auxLinearRegulatorBlank
);
    logic [7:0] ctrlSeen_r;  // Last ramp control write
    int         blankRun_r;  // Blank cycles since last load
    logic       auxWr;       // Accepted aux write
    logic       ctrlWr;      // Ramp control write
    assign auxWr = regWrEn && regAddr == 8'h1B && regWrProtected;
    assign ctrlWr = regWrEn && regAddr == 8'h1A;
    // Shadow of control bits and blank run length
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlSeen_r <= 8'h06;
            blankRun_r <= 0;
        end else begin
            if (ctrlWr) begin
                ctrlSeen_r <= regWrData;
            end
            // Restart wins over counting
            if (auxWr) begin
                blankRun_r <= 0;
            end else if (auxLinearRegulatorBlank) begin
                blankRun_r <= blankRun_r + 1;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    blank_start_a: assert property (auxWr |=> auxLinearRegulatorBlank)
        else $error("blanking did not start");
    blank_length_a: assert property ($fell(auxLinearRegulatorBlank) |-> blankRun_r == BLANK_LEN)
        else $error("blanking length wrong");
    unprot_ignore_a: assert property (regWrEn && regAddr == 8'h1B && !regWrProtected
        |=> $stable(auxLinearRegulatorCode) && !$rose(auxLinearRegulatorBlank)) else $error("unprotected write took");
    aux_load_a: assert property (auxWr |=> auxLinearRegulatorCode == $past(regWrData[5:0]))
        else $error("aux code not loaded");
    aux_read_a: assert property (regRdEn && regAddr == 8'h1B
        |=> regRdData == {2'b00, $past(auxLinearRegulatorCode)}) else $error("aux read wrong");
    ctrl_read_a: assert property (regRdEn && regAddr == 8'h1A
        |=> regRdData[6:0] == {$past(ctrlSeen_r[6]), 3'b000, $past(ctrlSeen_r[2:0])}) else $error("ctrl read wrong");
    unmapped_read_a: assert property (regRdEn && regAddr != 8'h1A && regAddr != 8'h1B
        |=> regRdData == 8'h00) else $error("unmapped read not zero");
    single_step_a: assert property (coreBuckOneLevel != $past(coreBuckOneLevel) && ctrlSeen_r[2:0] != 3'h7
        |-> (coreBuckOneLevel == $past(coreBuckOneLevel) + 1'b1 || coreBuckOneLevel == $past(coreBuckOneLevel) - 1'b1))
        else $error("level moved more than one code");
    update_hold_a: assert property (coreBuckOneUpdate && !ctrlSeen_r[6] && !rampBusy && !ctrlWr
        |=> $stable(coreBuckOneLevel)) else $error("update moved rail without trigger");
endmodule
bind rail_setpoint_slew_control rail_setpoint_monitor #(.CODE_W(CODE_W), .BLANK_LEN(BLANK_LEN)) mon (
    .clk(clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrProtected(regWrProtected), .regRdData(regRdData), .coreBuckOneUpdate(coreBuckOneUpdate),
    .coreBuckOneLevel(coreBuckOneLevel), .rampBusy(rampBusy), .auxLinearRegulatorCode(auxLinearRegulatorCode),
    .auxLinearRegulatorBlank(auxLinearRegulatorBlank));

/* File: verif/reg_host_model.sv */
// Register host and set-point source facing the ramp block
`timescale 1ns/10ps
module reg_host_model (
    // Clock
    input  wire logic  clk,
    // Register port
    output logic       regWrEn,
    output logic       regRdEn,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic       regWrProtected,
    // Set-points
    output logic [5:0] setOne,
    output logic [5:0] setTwo,
    output logic       updOne,
    output logic       updTwo
);
    // Idle at time zero
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrProtected = 1'b0;
        {setOne, setTwo, updOne, updTwo} = '0;
    end
    // One write, taken at the rising edge in between
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic p);
        @(negedge clk);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        regWrProtected = p;
        @(negedge clk);
        regWrEn = 1'b0;
        regWrData = ~d;  // Released data never echoes the last byte
    endtask
    // One read; data is valid on return
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        regRdEn = 1'b1;
        regAddr = a;
        @(negedge clk);
        regRdEn = 1'b0;
    endtask
    // New set-points with optional update pulses
    task automatic upd(input logic [5:0] one, input logic [5:0] two, input logic u1, input logic u2);
        @(negedge clk);
        setOne = one;
        setTwo = two;
        updOne = u1;
        updTwo = u2;
        @(negedge clk);
        updOne = 1'b0;
        updTwo = 1'b0;
    endtask
endmodule

/* File: verif/rail_setpoint_slew_control_tb.sv */
// Self-checking bench for the rail set-point ramp block
`timescale 1ns/10ps
module rail_setpoint_slew_control_tb;
    localparam int STEP_MIN = 2;   // Shortened fastest dwell
    localparam int BLANK = 20;     // Shortened blanking
    logic       clk;               // 200 MHz clock
    logic       rst_n;             // Async reset
    logic       wrEn, rdEn, prot;  // Register strobes
    logic [7:0] addr, wData, rData;
    logic [5:0] setOne, setTwo;    // Set-point sources
    logic       updOne, updTwo;
    logic [5:0] lvlOne, lvlTwo;    // Applied codes
    logic       busy, blank;
    logic [5:0] auxCode;
    int         fails;
    int         comparisons;
    reg_host_model host (.clk(clk), .regWrEn(wrEn), .regRdEn(rdEn), .regAddr(addr), .regWrData(wData),
        .regWrProtected(prot), .setOne(setOne), .setTwo(setTwo), .updOne(updOne), .updTwo(updTwo));
    rail_setpoint_slew_control #(.STEP_MIN(STEP_MIN), .BLANK_LEN(BLANK)) dut (.clk(clk), .rst_n(rst_n),
        .regWrEn(wrEn), .regRdEn(rdEn), .regAddr(addr), .regWrData(wData), .regWrProtected(prot),
        .regRdData(rData), .coreBuckOneSetpoint(setOne), .coreBuckOneUpdate(updOne),
        .coreBuckTwoSetpoint(setTwo), .coreBuckTwoUpdate(updTwo), .coreBuckOneLevel(lvlOne),
        .coreBuckTwoLevel(lvlTwo), .rampBusy(busy), .auxLinearRegulatorCode(auxCode),
        .auxLinearRegulatorBlank(blank));
    // Clock source
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk_val(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_lvl(input string n, input logic [5:0] e, input logic [5:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic chk_cnt(input string n, input int e, input int g);
        comparisons++;
        if (g != e) begin
            fails++;
            $display("ERROR %s expected %0d seen %0d", n, e, g);
        end
    endtask
    // Cycles until a rail leaves its old code, bounded
    task automatic lat(input logic sel, input logic [5:0] old, output int n);
        n = 0;
        while ((sel ? lvlTwo : lvlOne) === old && n < 2000) begin
            @(negedge clk);
            n++;
        end
    endtask
    // Wait for the ramp to finish, bounded
    task automatic idle_wait();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        repeat (2) @(negedge clk);
    endtask
    task automatic reset_check();
        host.rd(8'h1A);
        chk_val("ctrl reset", 8'h06, rData);
        host.rd(8'h1B);
        chk_val("aux reset", 8'h33, rData);
        host.rd(8'h1C);
        chk_val("unmapped", 8'h00, rData);
        chk_lvl("level one", 6'h00, lvlOne);
    endtask
    task automatic aux_check();
        int n;
        host.wr(8'h1B, 8'h05, 1'b0);
        chk_bit("blank unprot", 1'b0, blank);
        host.rd(8'h1B);
        chk_val("aux unprot", 8'h33, rData);
        host.wr(8'h1B, 8'hFF, 1'b1);
        chk_bit("aux busy", 1'b0, busy);
        chk_lvl("aux pins", 6'h3F, auxCode);
        n = 0;
        while (blank === 1'b1 && n < 200) begin
            n++;
            @(negedge clk);
        end
        chk_cnt("blank len", BLANK, n);
        host.rd(8'h1B);
        chk_val("aux code", 8'h3F, rData);
    endtask
    task automatic ramp_trigger();
        host.upd(6'h03, 6'h02, 1'b1, 1'b1);
        repeat (8) @(negedge clk);
        chk_lvl("no trigger", 6'h00, lvlOne);
        host.wr(8'h1A, 8'h83, 1'b0);
        chk_bit("ramp busy", 1'b1, busy);
        host.rd(8'h1A);
        chk_val("trig set", 8'h83, rData);
        host.wr(8'h1A, 8'h03, 1'b0);
        host.rd(8'h1A);
        chk_val("trig zero wr", 8'h83, rData);
        idle_wait();
        chk_lvl("rail one", 6'h03, lvlOne);
        chk_lvl("rail two", 6'h02, lvlTwo);
        host.rd(8'h1A);
        chk_val("trig clear", 8'h03, rData);
    endtask
    task automatic rate_sweep();
        int n;
        logic [5:0] o1, o2;
        for (int r = 0; r < 8; r++) begin
            o1 = lvlOne;
            o2 = lvlTwo;
            host.upd(o1 ^ 6'h01, o2 ^ 6'h01, 1'b0, 1'b0);
            host.wr(8'h1A, 8'h80 | 8'(r), 1'b0);
            lat(1'b0, o1, n);
            chk_cnt("dwell", (r == 7) ? 0 : (STEP_MIN << (6 - r)), n);
            idle_wait();
            chk_lvl("sweep two", o2 ^ 6'h01, lvlTwo);
        end
    endtask
    task automatic bypass_check();
        int n;
        logic [5:0] o1, o2;
        host.wr(8'h1A, 8'h46, 1'b0);
        o1 = lvlOne;
        o2 = lvlTwo;
        host.upd(o1 ^ 6'h02, o2 ^ 6'h01, 1'b0, 1'b1);
        lat(1'b1, o2, n);
        chk_cnt("bypass dwell", STEP_MIN, n);
        chk_lvl("rail one held", o1, lvlOne);
        idle_wait();
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        fails = 0;
        comparisons = 0;
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        reset_check();
        aux_check();
        ramp_trigger();
        rate_sweep();
        bypass_check();
        report_and_stop();
    end
endmodule
